/* design/prw_pkg.sv */
// Package of the reset, isolate and wake controller: constants and state types.
// Assumes a single 250 MHz clock domain on each end and no software registers.
package prw_pkg;
    // Bus type encoding of the sampled select pin
    localparam logic BUS_PCI = 1'b0;
    localparam logic BUS_CARDBUS = 1'b1;
    // Input synchroniser depth
    localparam int SYNC_DEPTH = 3;
    // Cap of the device clock-run counter; the device holds clock-run low as long as clock_busy stays high
    localparam int RESTART_PULSE = 2;
    // Host power-up sequence: cycles isolate stays active after power good
    localparam int STABLE_TIME_NS = 400;
    localparam int STABLE_CYCLES = (STABLE_TIME_NS + 3) / 4;
    typedef enum logic [1:0] {PRW_OFF, PRW_RESET, PRW_RUN} prw_host_state_t;
    typedef enum logic [1:0] {PRW_TARGET, PRW_MASTER} prw_dev_mode_t;
endpackage : prw_pkg

/* design/prw_if.sv */
// Wires between the device end and the host end of the reset/wake link.
// Assumes this interface resolves open-drain lines from the enables.
`timescale 1ns/1ps
`default_nettype none
interface prw_if;
    logic pci_rst_n;
    logic isolate_n;
    logic pci_power_good;
    logic flash_addr_bit0;
    logic io_level_sense;
    logic clock_run_n_dev_o;
    logic clock_run_n_dev_oe;
    logic clock_run_n_host_o;
    logic clock_run_n_host_oe;
    logic clock_run_n;
    logic pme_n_oe;
    logic pme_n;
    logic wake_out_high;
    logic bus_oe;
    logic bus_master_en;
    // Open-drain and shared lines resolved here, low wins, pulled high otherwise
    assign clock_run_n = !((clock_run_n_dev_oe && !clock_run_n_dev_o) || (clock_run_n_host_oe && !clock_run_n_host_o));
    assign pme_n = !pme_n_oe;
    modport device (input pci_rst_n, input isolate_n, input flash_addr_bit0, input io_level_sense,
        input clock_run_n, input bus_master_en, output clock_run_n_dev_o, output clock_run_n_dev_oe,
        output pme_n_oe, output wake_out_high, output bus_oe);
    modport host (output pci_rst_n, output isolate_n, output pci_power_good, output flash_addr_bit0,
        output io_level_sense, output clock_run_n_host_o, output clock_run_n_host_oe, output bus_master_en,
        input clock_run_n, input pme_n, input wake_out_high);
endinterface : prw_if
`default_nettype wire

/* design/prw_device.sv */
// Device end: reset, isolate, mode sampling, clock-run and wake signalling.
// Assumes link pins are asynchronous and pass three flip-flops.
`timescale 1ns/1ps
`default_nettype none
module prw_device (
    input wire logic ref_clk,
    input wire logic power_on_reset_n,
    prw_if.device link,
    input wire logic wake_event,
    input wire logic wake_enable,
    input wire logic pme_status_clear,
    input wire logic clock_busy,
    output logic pme_status,
    output logic bus_type,
    output logic io_level_5v,
    output logic master_active
);
    // Three-stage synchronisers; only stages 2 and 3 are looked at
    logic [2:0] rst_s_reg, iso_s_reg, sel_s_reg, vio_s_reg, crun_s_reg, men_s_reg;
    logic [2:0] rst_s_next, iso_s_next, sel_s_next, vio_s_next, crun_s_next, men_s_next;
    logic rst_f_reg, iso_f_reg, crun_f_reg, men_f_reg;
    logic rst_f_next, iso_f_next, crun_f_next, men_f_next;
    logic bus_type_reg, bus_type_next, vio_reg, vio_next;
    logic pme_st_reg, pme_st_next, pme_armed_reg, pme_armed_next;
    logic [1:0] crun_cnt_reg, crun_cnt_next;
    prw_pkg::prw_dev_mode_t mode_reg, mode_next;
    logic in_reset, isolated;

    // Filtered level: change accepted when stages 2 and 3 agree
    function automatic logic filt(input logic [2:0] s, input logic cur);
        filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction : filt

    // Synchroniser and filter next state
    always_comb begin
        rst_s_next = {rst_s_reg[1:0], link.pci_rst_n};
        iso_s_next = {iso_s_reg[1:0], link.isolate_n};
        sel_s_next = {sel_s_reg[1:0], link.flash_addr_bit0};
        vio_s_next = {vio_s_reg[1:0], link.io_level_sense};
        crun_s_next = {crun_s_reg[1:0], link.clock_run_n};
        men_s_next = {men_s_reg[1:0], link.bus_master_en};
        iso_f_next = filt(iso_s_reg, iso_f_reg);
        // Isolated: reset and other inputs frozen, so a dying bus cannot reset us
        rst_f_next = isolated ? rst_f_reg : filt(rst_s_reg, rst_f_reg);
        crun_f_next = isolated ? crun_f_reg : filt(crun_s_reg, crun_f_reg);
        men_f_next = isolated ? men_f_reg : filt(men_s_reg, men_f_reg);
    end

    assign isolated = !iso_f_reg;
    assign in_reset = !rst_f_reg;

    // Mode straps, wake and clock-run next state
    always_comb begin
        bus_type_next = bus_type_reg;
        vio_next = vio_reg;
        mode_next = mode_reg;
        pme_st_next = pme_st_reg;
        pme_armed_next = pme_armed_reg;
        crun_cnt_next = '0;
        if (in_reset && !isolated) begin
            // Straps follow the pins during reset while not isolated; last value held on release
            bus_type_next = sel_s_reg[2] ? prw_pkg::BUS_CARDBUS : prw_pkg::BUS_PCI;
            vio_next = vio_s_reg[2];
            mode_next = prw_pkg::PRW_TARGET;
        end else if (!isolated) begin
            mode_next = men_f_reg ? prw_pkg::PRW_MASTER : prw_pkg::PRW_TARGET;
        end
        // Wake: one event per arming, set wins over clear only while armed
        if (pme_status_clear) begin
            pme_st_next = 1'b0;
            pme_armed_next = 1'b1;
        end
        if (wake_event && wake_enable && pme_armed_reg) begin
            pme_st_next = 1'b1;
            pme_armed_next = 1'b0;
        end
        // Hold clock-run low while busy or to ask for restart
        if (!isolated && !in_reset && clock_busy && (crun_f_reg || crun_cnt_reg != 2'd0)) begin
            crun_cnt_next = (crun_cnt_reg == 2'(prw_pkg::RESTART_PULSE)) ? crun_cnt_reg : crun_cnt_reg + 2'd1;
        end
    end

    // Registers; power-on reset clears aux state too
    always_ff @(posedge ref_clk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            rst_s_reg <= '0;
            iso_s_reg <= '0;
            sel_s_reg <= '0;
            vio_s_reg <= '0;
            crun_s_reg <= '0;
            men_s_reg <= '0;
            rst_f_reg <= 1'b0;
            iso_f_reg <= 1'b0;
            crun_f_reg <= 1'b0;
            men_f_reg <= 1'b0;
            bus_type_reg <= prw_pkg::BUS_PCI;
            vio_reg <= 1'b0;
            mode_reg <= prw_pkg::PRW_TARGET;
            pme_st_reg <= 1'b0;
            pme_armed_reg <= 1'b1;
            crun_cnt_reg <= '0;
        end else begin
            rst_s_reg <= rst_s_next;
            iso_s_reg <= iso_s_next;
            sel_s_reg <= sel_s_next;
            vio_s_reg <= vio_s_next;
            crun_s_reg <= crun_s_next;
            men_s_reg <= men_s_next;
            rst_f_reg <= rst_f_next;
            iso_f_reg <= iso_f_next;
            crun_f_reg <= crun_f_next;
            men_f_reg <= men_f_next;
            bus_type_reg <= bus_type_next;
            vio_reg <= vio_next;
            mode_reg <= mode_next;
            pme_st_reg <= pme_st_next;
            pme_armed_reg <= pme_armed_next;
            crun_cnt_reg <= crun_cnt_next;
        end
    end

    // Pins: bus floats in reset or isolate; wake lines stay live
    assign link.bus_oe = !in_reset && !isolated;
    assign link.clock_run_n_dev_o = 1'b0;
    assign link.clock_run_n_dev_oe = !in_reset && !isolated && (crun_cnt_reg != 2'd0);
    assign link.pme_n_oe = pme_st_reg;
    assign link.wake_out_high = pme_st_reg;
    assign pme_status = pme_st_reg;
    assign bus_type = bus_type_reg;
    assign io_level_5v = vio_reg;
    assign master_active = (mode_reg == prw_pkg::PRW_MASTER);
endmodule : prw_device
`default_nettype wire

/* design/prw_host.sv */
// Host end: power-good, isolate and PCI reset sequencing, clock-run, wake sense.
// Assumes the user side gives a power request level and strap values.
`timescale 1ns/1ps
`default_nettype none
module prw_host #(
    parameter int STABLE = prw_pkg::STABLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    prw_if.host link,
    input wire logic power_req,
    input wire logic strap_cardbus,
    input wire logic strap_5v,
    input wire logic master_req,
    input wire logic clock_stop_req,
    output logic clock_stopped,
    output logic wake_seen,
    output logic bus_ready
);
    // Settle counter is 16 bits wide; longer settle times need a wider counter
    if (STABLE < 1 || STABLE > 65535) begin : g_stable_bad
        $error("STABLE out of range");
    end
    prw_pkg::prw_host_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [2:0] pme_s_reg, pme_s_next, cr_s_reg, cr_s_next;
    logic stop_reg, stop_next, wake_reg, wake_next;

    // Power sequence: isolate active before power good, held until stable
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        pme_s_next = {pme_s_reg[1:0], link.pme_n};
        cr_s_next = {cr_s_reg[1:0], link.clock_run_n};
        wake_next = (pme_s_reg[1] == pme_s_reg[2]) ? !pme_s_reg[2] : wake_reg;
        stop_next = stop_reg;
        unique case (st_reg)
            prw_pkg::PRW_OFF: begin
                cnt_next = '0;
                if (power_req) st_next = prw_pkg::PRW_RESET;
            end
            prw_pkg::PRW_RESET: begin
                cnt_next = cnt_reg + 16'd1;
                if (!power_req) st_next = prw_pkg::PRW_OFF;
                else if (cnt_reg == 16'(STABLE - 1)) st_next = prw_pkg::PRW_RUN;
            end
            prw_pkg::PRW_RUN: begin
                if (!power_req) st_next = prw_pkg::PRW_OFF;
            end
        endcase
        // Stop clock only while no one holds clock-run low
        if (st_reg != prw_pkg::PRW_RUN || !clock_stop_req) stop_next = 1'b0;
        else if (cr_s_reg[1] == cr_s_reg[2] && cr_s_reg[2]) stop_next = 1'b1;
        else if (cr_s_reg[1] == cr_s_reg[2]) stop_next = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= prw_pkg::PRW_OFF;
            cnt_reg <= '0;
            pme_s_reg <= 3'h7;
            cr_s_reg <= 3'h0;
            stop_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            pme_s_reg <= pme_s_next;
            cr_s_reg <= cr_s_next;
            stop_reg <= stop_next;
            wake_reg <= wake_next;
        end
    end

    // Isolate low whenever not running, so it precedes power good
    assign link.isolate_n = (st_reg == prw_pkg::PRW_RUN);
    assign link.pci_power_good = (st_reg != prw_pkg::PRW_OFF);
    assign link.pci_rst_n = (st_reg == prw_pkg::PRW_RUN);
    assign link.flash_addr_bit0 = strap_cardbus;
    assign link.io_level_sense = strap_5v;
    assign link.bus_master_en = master_req && (st_reg == prw_pkg::PRW_RUN);
    assign link.clock_run_n_host_o = 1'b0;
    // Host pulls low to say the clock runs when not stopping
    assign link.clock_run_n_host_oe = !clock_stop_req && (st_reg == prw_pkg::PRW_RUN);
    assign clock_stopped = stop_reg;
    assign wake_seen = wake_reg;
    assign bus_ready = (st_reg == prw_pkg::PRW_RUN);
endmodule : prw_host
`default_nettype wire

/* sim/prw_link_chk.sv */
// Checker on the wires between host end and device end.
// Assumes one clock and the host reset rst_b, active low.
`timescale 1ns/1ps
`default_nettype none
module prw_link_chk #(
    parameter int STABLE = prw_pkg::STABLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pci_rst_n,
    input wire logic isolate_n,
    input wire logic pci_power_good,
    input wire logic clock_run_n_dev_o,
    input wire logic clock_run_n_dev_oe,
    input wire logic pme_n_oe,
    input wire logic pme_n,
    input wire logic wake_out_high,
    input wire logic bus_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic [7:0] pg_cnt_reg;
    logic [7:0] pg_cnt_next;
    // Cycles of power good; saturates so long runs never wrap
    always_comb begin
        pg_cnt_next = pg_cnt_reg;
        if (!pci_power_good) pg_cnt_next = 8'h00;
        else if (pg_cnt_reg != 8'hff) pg_cnt_next = pg_cnt_reg + 8'h01;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) pg_cnt_reg <= 8'h00;
        else pg_cnt_reg <= pg_cnt_next;
    end
    a_wake_mirror: assert property (wake_out_high == pme_n_oe)
        else $error("wake output differs from event output");
    a_float_reset: assert property ((!pci_rst_n)[*5] |-> !bus_oe)
        else $error("bus driven during reset");
    a_float_iso: assert property ((!isolate_n)[*5] |-> !bus_oe)
        else $error("bus driven while isolated");
    a_iso_before_pg: assert property ($rose(pci_power_good) |-> !isolate_n)
        else $error("power good raised while not isolated");
    a_iso_hold: assert property ($rose(pci_power_good) |=> (!isolate_n)[*3])
        else $error("isolate released too early");
    a_release_late: assert property ($rose(isolate_n) |-> int'(pg_cnt_reg) >= STABLE)
        else $error("isolate released before stable time");
    a_release_together: assert property ($rose(isolate_n) |-> pci_rst_n)
        else $error("isolate released ahead of reset");
    a_clock_run_n_drain: assert property (clock_run_n_dev_oe |-> (!clock_run_n_dev_o && bus_oe))
        else $error("clock run driven high or while off the bus");
    // Main scenarios reached
    c_wake: cover property ($fell(pme_n));
    c_release: cover property ($rose(isolate_n));
    c_bus_on: cover property (bus_oe);
endmodule : prw_link_chk
`default_nettype wire

/* sim/pci_reset_isolate_wake_ctrl_tb.sv */
// Bench joining host end and device end through the link interface.
// Assumes a 250 MHz clock and host straps as the only mode source.
`timescale 1ns/1ps
`default_nettype none
module pci_reset_isolate_wake_ctrl_tb;
    localparam int STABLE_SIM = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic power_on_reset_n = 1'b0;
    logic wake_event = 1'b0, wake_enable = 1'b0, pme_status_clear = 1'b0, clock_busy = 1'b0;
    logic power_req = 1'b0, strap_cardbus = 1'b0, strap_5v = 1'b0, master_req = 1'b0, clock_stop_req = 1'b0;
    logic pme_status, bus_type, io_level_5v, master_active, clock_stopped, wake_seen, bus_ready;
    logic [31:0] lfsr_reg = 32'h259a;
    int num_errors = 0;
    int total_checks = 0;
    prw_if link_if ();
    // Both ends face each other; checker watches the wires
    prw_device u_prw_device (.ref_clk(ref_clk), .power_on_reset_n(power_on_reset_n), .link(link_if),
        .wake_event(wake_event), .wake_enable(wake_enable), .pme_status_clear(pme_status_clear),
        .clock_busy(clock_busy), .pme_status(pme_status), .bus_type(bus_type), .io_level_5v(io_level_5v),
        .master_active(master_active));
    prw_host #(.STABLE(STABLE_SIM)) u_prw_host (.ref_clk(ref_clk), .rst_b(rst_b), .link(link_if),
        .power_req(power_req), .strap_cardbus(strap_cardbus), .strap_5v(strap_5v), .master_req(master_req),
        .clock_stop_req(clock_stop_req), .clock_stopped(clock_stopped), .wake_seen(wake_seen),
        .bus_ready(bus_ready));
    prw_link_chk #(.STABLE(STABLE_SIM)) u_prw_link_chk (.ref_clk(ref_clk), .rst_b(rst_b),
        .pci_rst_n(link_if.pci_rst_n), .isolate_n(link_if.isolate_n), .pci_power_good(link_if.pci_power_good),
        .clock_run_n_dev_o(link_if.clock_run_n_dev_o), .clock_run_n_dev_oe(link_if.clock_run_n_dev_oe),
        .pme_n_oe(link_if.pme_n_oe), .pme_n(link_if.pme_n), .wake_out_high(link_if.wake_out_high),
        .bus_oe(link_if.bus_oe));
    // Free-running clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Galois LFSR; fixed start keeps runs repeatable
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr_step
    // Expected strap bit: index 1 bus type, index 0 level
    function automatic logic exp_strap(input logic [1:0] s, input int i);
        return s[i];
    endfunction : exp_strap
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // Full host power cycle; extra wait covers the device synchronisers
    task automatic power_up(input logic [1:0] s);
        power_req = 1'b0;
        step(4);
        strap_cardbus = s[1];
        strap_5v = s[0];
        power_req = 1'b1;
        for (int i = 0; i < 100 && bus_ready !== 1'b1; i++) step(1);
        step(8);
    endtask : power_up
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
        step(1);
    endtask : pulse
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #40000;
        num_errors++;
        summarize();
    end
    initial begin
        logic [1:0] s;
        step(6);
        rst_b = 1'b1;
        power_on_reset_n = 1'b1;
        for (int k = 0; k < 6; k++) begin
            lfsr_reg = lfsr_step(lfsr_reg);
            s = (k < 4) ? 2'(k) : lfsr_reg[1:0];
            power_up(s);
            chk(bus_ready, 1'b1);
            chk(bus_type, exp_strap(s, 1));
            chk(io_level_5v, exp_strap(s, 0));
            strap_cardbus = ~s[1];
            strap_5v = ~s[0];
            step(8);
            chk(bus_type, exp_strap(s, 1));
            chk(io_level_5v, exp_strap(s, 0));
        end
        chk(master_active, 1'b0);
        master_req = 1'b1;
        step(10);
        chk(master_active, 1'b1);
        clock_busy = 1'b1;
        clock_stop_req = 1'b1;
        step(20);
        chk(clock_stopped, 1'b0);
        clock_busy = 1'b0;
        for (int i = 0; i < 50 && clock_stopped !== 1'b1; i++) step(1);
        chk(clock_stopped, 1'b1);
        clock_stop_req = 1'b0;
        pulse(wake_event);
        chk(link_if.pme_n, 1'b1);
        wake_enable = 1'b1;
        pulse(wake_event);
        chk(link_if.pme_n, 1'b0);
        chk(link_if.wake_out_high, 1'b1);
        step(6);
        chk(wake_seen, 1'b1);
        pulse(pme_status_clear);
        chk(link_if.pme_n, 1'b1);
        chk(link_if.wake_out_high, 1'b0);
        power_req = 1'b0;
        step(8);
        chk(link_if.bus_oe, 1'b0);
        chk(bus_ready, 1'b0);
        // Strap differs from the latched value; isolation must hide it
        strap_cardbus = ~s[1];
        step(8);
        chk(bus_type, exp_strap(s, 1));
        step(1 + int'(lfsr_reg[2:0]));
        pulse(wake_event);
        chk(pme_status, 1'b1);
        chk(link_if.pme_n, 1'b0);
        power_on_reset_n = 1'b0;
        step(2);
        chk(pme_status, 1'b0);
        chk(link_if.pme_n, 1'b1);
        chk(master_active, 1'b0);
        summarize();
    end
endmodule : pci_reset_isolate_wake_ctrl_tb
`default_nettype wire
